// [hdl/boiler_consts.svh]
// Constant names for the burner controller upper register bank.
`ifndef BOILER_CONSTS_SVH
`define BOILER_CONSTS_SVH
`define ADDR_PASSCODE 16'h0520
`define ADDR_LABEL 16'h0530
`define ADDR_NOTE 16'h0540
`define ADDR_MAKER_ID 16'h0550
`define ADDR_BANK_LAST 16'h0fff
`define WINDOW_WORDS 16'h000a
`define TEXT_RESET 16'h0000
`define EXC_ILLEGAL_ADDR 8'h02
`define EXC_DENIED 8'h03
`define LEVEL_MAKER 2'h2
`define TEMP_MIN 16'hfe70
`define TEMP_MAX 16'h0514
`define TEMP_UNCONFIGURED 16'h8fff
`define STEP_MAX 8'hc8
`define STEP_TENTHS 11'h005
`define FRACTION_SCALE 19'h003e8
`define RATE_FORMAT_BIT 8
`define SPEED_UNIT_BIT 15
`define LOC_LAST 16'h0004
`define CODE_NONE 16'h0000
`define CODE_LAST_LISTED 16'h000f
`endif

// [hdl/boiler_control_register_map.sv]
// Upper register bank and value codecs of the burner controller.
// Functional notes
// - Maker passcode written only at maker level, mirrored.
// - Three read/write ten-word text windows, aliased lower.
// - Temperatures in tenths Celsius, -40 to 130.
// - Disabled temperature reads 0x8FFF.
// - Percentages in tenths, 0 to 1000.
// - Speed top bit picks unit; mismatch invalid.
// - Safety changes need login, then verification.
// - Rate low byte; bit 8 selects format.
// - Step format: 0 to 200 half percents.
// - Fraction format: unsigned fraction of one.
// - Space heating rate decoded per format.
// - Demand mode switches burner on demand one cycle later.
// - Lockout history record fixed byte order.
// - Bytes 22-23 inlet or steam by product.
// - Annunciator record location code zero to four.
// - Interlock naming record short and full names.
// - Code 0 none; codes 1, 2 lockouts.
// - Codes 3-9,12 hold; 10,11,15 lockout; 13,14 either.
`timescale 1ns/10ps
`default_nettype none
`include "boiler_consts.svh"
module boiler_control_register_map (
  input wire logic clock,
  input wire logic reset_n,
  input wire boiler_pkg::reg_req_s req,
  output boiler_pkg::reg_rsp_s rsp,
  input wire logic [1:0] accessLevel,
  output logic [159:0] makerPasscode,
  output logic [159:0] labelText,
  output logic [159:0] noteText,
  output logic [159:0] makerIdText,
  input wire logic [15:0] rawTemp,
  input wire logic tempEnabled,
  output logic [15:0] tempReg,
  input wire logic [15:0] speedWord,
  input wire logic modOutIsPercent,
  output logic speedInvalid,
  input wire logic [15:0] rateWord,
  output logic [10:0] rateTenths,
  output logic rateValid,
  input wire logic safetyChangeReq,
  input wire logic loginOk,
  input wire logic verifyDone,
  output logic safetyChangeAccept,
  output logic verifyPending,
  input wire boiler_pkg::mod_source_e modSource,
  input wire logic heatDemand,
  input wire logic [15:0] loopTemp,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] hysteresis,
  output logic burnerOn,
  input wire logic captureLockout,
  input wire logic productIsSteam,
  input wire boiler_pkg::lockout_snap_s snap,
  output boiler_pkg::lockout_rec_s historyRec,
  input wire boiler_pkg::annunciator_rec_s annRec,
  input wire boiler_pkg::interlock_rec_s ilkRec,
  output logic annLocValid,
  output logic [23:0] ilkShortName,
  input wire logic [15:0] faultCode,
  input wire logic dualAsLockout,
  output boiler_pkg::fault_class_e faultClass
);
  import boiler_pkg::*;

  localparam int WORDS = int'(`WINDOW_WORDS);

  logic [15:0] passQ [WORDS];
  logic [15:0] passD [WORDS];
  logic [15:0] textQ [3][WORDS];
  logic [15:0] textD [3][WORDS];
  reg_rsp_s rspQ, rspD;
  logic [15:0] offPass, offText [3];
  logic inPass, inText [3];

  // Window hits; the subtraction wraps so addresses below a base miss.
  assign offPass = req.addr - `ADDR_PASSCODE;
  assign offText[0] = req.addr - `ADDR_LABEL;
  assign offText[1] = req.addr - `ADDR_NOTE;
  assign offText[2] = req.addr - `ADDR_MAKER_ID;
  assign inPass = offPass < `WINDOW_WORDS;
  assign inText[0] = offText[0] < `WINDOW_WORDS;
  assign inText[1] = offText[1] < `WINDOW_WORDS;
  assign inText[2] = offText[2] < `WINDOW_WORDS;

  // Register access: one answer per request, one cycle later.
  always_comb begin
    passD = passQ;
    textD = textQ;
    rspD = '0;
    rspD.valid = req.valid;
    if (req.valid) begin
      if (req.addr < `ADDR_PASSCODE || req.addr > `ADDR_BANK_LAST) begin
        rspD.exc = 1'b1;
        rspD.excCode = `EXC_ILLEGAL_ADDR;
      end else if (inPass) begin
        if (!req.write) begin
          rspD.exc = 1'b1;
          rspD.excCode = `EXC_ILLEGAL_ADDR;
        end else if (accessLevel < `LEVEL_MAKER) begin
          rspD.exc = 1'b1;
          rspD.excCode = `EXC_DENIED;
        end else begin
          passD[offPass[3:0]] = req.data;
        end
      end else begin
        for (int t = 0; t < 3; t++) begin
          if (inText[t]) begin
            if (req.write) begin
              textD[t][offText[t][3:0]] = req.data;
            end else begin
              rspD.data = textQ[t][offText[t][3:0]];
            end
          end
        end
        // Reserved gaps fall through here: data stays zero, writes drop.
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rspQ <= '0;
      for (int w = 0; w < WORDS; w++) begin
        passQ[w] <= `TEXT_RESET;
        for (int t = 0; t < 3; t++) begin
          textQ[t][w] <= `TEXT_RESET;
        end
      end
    end else begin
      rspQ <= rspD;
      passQ <= passD;
      textQ <= textD;
    end
  end

  assign rsp = rspQ;

  // Flatten the windows so the lower aliases see the same storage.
  for (genvar w = 0; w < WORDS; w++) begin : g_flat
    assign makerPasscode[16*w +: 16] = passQ[w];
    assign labelText[16*w +: 16] = textQ[0][w];
    assign noteText[16*w +: 16] = textQ[1][w];
    assign makerIdText[16*w +: 16] = textQ[2][w];
  end

  // Value codecs. A disabled sensor reports the marker, never a clamped value.
  logic [15:0] tempQ, tempD;
  logic speedBadQ, speedBadD;
  logic [10:0] rateQ, rateD;
  logic rateOkQ, rateOkD;
  logic [18:0] fracProduct;

  assign fracProduct = 19'(rateWord[7:0]) * `FRACTION_SCALE;

  always_comb begin
    if (!tempEnabled) begin
      tempD = `TEMP_UNCONFIGURED;
    end else if ($signed(rawTemp) < $signed(`TEMP_MIN)) begin
      tempD = `TEMP_MIN;
    end else if ($signed(rawTemp) > $signed(`TEMP_MAX)) begin
      tempD = `TEMP_MAX;
    end else begin
      tempD = rawTemp;
    end
    speedBadD = speedWord[`SPEED_UNIT_BIT] != modOutIsPercent;
    if (rateWord[`RATE_FORMAT_BIT]) begin
      rateD = fracProduct[18:8];
      rateOkD = 1'b1;
    end else begin
      rateD = 11'(rateWord[7:0] * `STEP_TENTHS);
      rateOkD = rateWord[7:0] <= `STEP_MAX;
      if (!rateOkD) begin
        rateD = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tempQ <= `TEMP_UNCONFIGURED;
      speedBadQ <= 1'b0;
      rateQ <= '0;
      rateOkQ <= 1'b0;
    end else begin
      tempQ <= tempD;
      speedBadQ <= speedBadD;
      rateQ <= rateD;
      rateOkQ <= rateOkD;
    end
  end

  assign tempReg = tempQ;
  assign speedInvalid = speedBadQ;
  assign rateTenths = rateQ;
  assign rateValid = rateOkQ;

  // Safety gate; a new change while verification is cleared still sets it.
  logic acceptQ, acceptD, pendQ, pendD;

  always_comb begin
    acceptD = safetyChangeReq && loginOk;
    pendD = pendQ;
    if (verifyDone) begin
      pendD = 1'b0;
    end
    if (acceptD) begin
      pendD = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acceptQ <= 1'b0;
      pendQ <= 1'b0;
    end else begin
      acceptQ <= acceptD;
      pendQ <= pendD;
    end
  end

  assign safetyChangeAccept = acceptQ;
  assign verifyPending = pendQ;

  // Burner switching; sensor mode keeps state inside the hysteresis band.
  logic burnQ, burnD;

  always_comb begin
    burnD = burnQ;
    case (modSource)
      MOD_DEMAND_SWITCH: begin
        burnD = heatDemand;
      end
      MOD_SENSOR_SWITCH: begin
        if ($signed(loopTemp) >= $signed(setpoint)) begin
          burnD = 1'b0;
        end else if ($signed(loopTemp) < $signed(setpoint - hysteresis)) begin
          burnD = 1'b1;
        end
      end
      default: begin
        burnD = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      burnQ <= 1'b0;
    end else begin
      burnQ <= burnD;
    end
  end

  assign burnerOn = burnQ;

  // Lockout history capture and record checks.
  lockout_rec_s recQ, recD;
  logic annOkQ, annOkD;
  logic [23:0] ilkNameQ, ilkNameD;

  always_comb begin
    recD = recQ;
    if (captureLockout) begin
      recD.code = snap.code;
      recD.firstOut = snap.firstOut;
      recD.burnerState = snap.burnerState;
      recD.seqTime = snap.seqTime;
      recD.cycles = snap.cycles;
      recD.hours = snap.hours;
      recD.io = snap.io;
      recD.annunciator = snap.annunciator;
      recD.outletTemp = snap.outletTemp;
      recD.inletOrSteam = productIsSteam ? snap.steamPressure : snap.inletTemp;
      recD.hotWaterTemp = snap.hotWaterTemp;
      recD.outdoorTemp = snap.outdoorTemp;
      recD.stackTemp = snap.stackTemp;
      recD.loopInput = snap.loopInput;
      recD.faultByte0 = snap.faultData[15:8];
      recD.faultByte1 = snap.faultData[7:0];
    end
    annOkD = annRec.location <= `LOC_LAST;
    ilkNameD = ilkRec.shortName;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      recQ <= '0;
      annOkQ <= 1'b0;
      ilkNameQ <= '0;
    end else begin
      recQ <= recD;
      annOkQ <= annOkD;
      ilkNameQ <= ilkNameD;
    end
  end

  assign historyRec = recQ;
  assign annLocValid = annOkQ;
  assign ilkShortName = ilkNameQ;

  // Lockout/hold classification of the first sixteen codes.
  fault_class_e classQ, classD;

  always_comb begin
    if (faultCode == `CODE_NONE) begin
      classD = CLASS_NONE;
    end else if (faultCode > `CODE_LAST_LISTED) begin
      classD = CLASS_UNLISTED;
    end else begin
      case (faultCode[3:0])
        4'h1, 4'h2: classD = CLASS_LOCKOUT;
        4'ha, 4'hb, 4'hf: classD = CLASS_LOCKOUT;
        4'hd, 4'he: classD = dualAsLockout ? CLASS_LOCKOUT : CLASS_HOLD;
        default: classD = CLASS_HOLD;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      classQ <= CLASS_NONE;
    end else begin
      classQ <= classD;
    end
  end

  assign faultClass = classQ;

  // Checks on the bank and the codecs.
  chk_pass_denied: assert property (@(posedge clock) disable iff (!reset_n)
    req.valid && req.write && inPass && accessLevel < `LEVEL_MAKER
    |=> rsp.exc && makerPasscode == $past(makerPasscode))
    else $error("Passcode write accepted below maker level.");
  chk_pass_taken: assert property (@(posedge clock) disable iff (!reset_n)
    req.valid && req.write && inPass && accessLevel >= `LEVEL_MAKER
    |=> !rsp.exc && makerPasscode[16*$past(offPass[3:0]) +: 16] == $past(req.data))
    else $error("Passcode write not mirrored.");
  chk_text_readback: assert property (@(posedge clock) disable iff (!reset_n)
    req.valid && req.write && inText[0] ##1 req.valid && !req.write && req.addr == $past(req.addr)
    |=> rsp.data == $past(req.data, 2))
    else $error("Label window did not read back.");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
    req.valid && !req.write && req.addr >= `ADDR_PASSCODE && req.addr <= `ADDR_BANK_LAST
    && !inPass && !inText[0] && !inText[1] && !inText[2] |=> rsp.valid && !rsp.exc && rsp.data == '0)
    else $error("Reserved read not zero.");
  chk_temp_marker: assert property (@(posedge clock) disable iff (!reset_n)
    !tempEnabled |=> tempReg == `TEMP_UNCONFIGURED)
    else $error("Disabled temperature lacks marker.");
  chk_rate_step: assert property (@(posedge clock) disable iff (!reset_n)
    !rateWord[`RATE_FORMAT_BIT] && rateWord[7:0] == `STEP_MAX |=> rateTenths == 11'h3e8 && rateValid)
    else $error("Full step rate not 100 percent.");
  chk_verify_set: assert property (@(posedge clock) disable iff (!reset_n)
    safetyChangeReq && !loginOk |=> !safetyChangeAccept && (verifyPending == $past(verifyPending)
    || $past(verifyDone)))
    else $error("Safety change taken without login.");
  chk_demand_follow: assert property (@(posedge clock) disable iff (!reset_n)
    modSource == MOD_DEMAND_SWITCH |=> burnerOn == $past(heatDemand))
    else $error("Burner did not follow demand.");
  chk_fault_class: assert property (@(posedge clock) disable iff (!reset_n)
    faultCode == 16'h000a || faultCode == 16'h0002 |=> faultClass == CLASS_LOCKOUT)
    else $error("Lockout code misclassified.");
  chk_speed_unit: assert property (@(posedge clock) disable iff (!reset_n)
    speedWord[`SPEED_UNIT_BIT] == modOutIsPercent |=> !speedInvalid)
    else $error("Matching speed unit flagged invalid.");
  cov_pass_write: cover property (@(posedge clock) req.valid && req.write && inPass);
  cov_unmapped: cover property (@(posedge clock) rsp.valid && rsp.exc);
  cov_capture: cover property (@(posedge clock) captureLockout && productIsSteam);
  cov_sensor_on: cover property (@(posedge clock) modSource == MOD_SENSOR_SWITCH ##1 $rose(burnerOn));
endmodule
`default_nettype wire

// [hdl/boiler_pkg.sv]
// Types shared by the burner controller register bank and its users.
package boiler_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
  } reg_req_s;
  typedef struct packed {
    logic valid;
    logic exc;
    logic [7:0] excCode;
    logic [15:0] data;
  } reg_rsp_s;
  typedef enum logic [1:0] {MOD_SENSOR_SWITCH, MOD_DEMAND_SWITCH, MOD_OTHER} mod_source_e;
  typedef enum logic [1:0] {CLASS_NONE, CLASS_HOLD, CLASS_LOCKOUT, CLASS_UNLISTED} fault_class_e;
  // Live values captured into a lockout history record.
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] firstOut;
    logic [15:0] burnerState;
    logic [15:0] seqTime;
    logic [31:0] cycles;
    logic [31:0] hours;
    logic [15:0] io;
    logic [15:0] annunciator;
    logic [15:0] outletTemp;
    logic [15:0] inletTemp;
    logic [15:0] steamPressure;
    logic [15:0] hotWaterTemp;
    logic [15:0] outdoorTemp;
    logic [15:0] stackTemp;
    logic [15:0] loopInput;
    logic [15:0] faultData;
  } lockout_snap_s;
  // Byte 0 is the most significant slice; 34 bytes in all.
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] firstOut;
    logic [15:0] burnerState;
    logic [15:0] seqTime;
    logic [31:0] cycles;
    logic [31:0] hours;
    logic [15:0] io;
    logic [15:0] annunciator;
    logic [15:0] outletTemp;
    logic [15:0] inletOrSteam;
    logic [15:0] hotWaterTemp;
    logic [15:0] outdoorTemp;
    logic [15:0] stackTemp;
    logic [15:0] loopInput;
    logic [7:0] faultByte0;
    logic [7:0] faultByte1;
  } lockout_rec_s;
  // Annunciator configuration record, 26 bytes.
  typedef struct packed {
    logic [15:0] location;
    logic [23:0] shortName;
    logic [7:0] unused;
    logic [159:0] fullName;
  } annunciator_rec_s;
  // Interlock terminal naming record, 24 bytes.
  typedef struct packed {
    logic [23:0] shortName;
    logic [7:0] unused;
    logic [159:0] fullName;
  } interlock_rec_s;
endpackage

// [testbench/boiler_control_register_map_tb.sv]
// Self-checking bench for the burner controller register bank.
`timescale 1ns/10ps
`default_nettype none
`include "boiler_consts.svh"
module boiler_control_register_map_tb;
  import boiler_pkg::*;
  logic clock = 1'b0, resetN = 1'b0;
  reg_req_s req;
  reg_rsp_s rsp;
  logic [1:0] accessLevel = 2'h0;
  logic [159:0] makerPasscode, labelText, noteText, makerIdText;
  logic [15:0] rawTemp = 16'h0, tempReg, speedWord = 16'h0, rateWord = 16'h0;
  logic tempEnabled = 1'b0, modOutIsPercent = 1'b0, speedInvalid, rateValid;
  logic [10:0] rateTenths;
  logic safetyChangeReq = 1'b0, loginOk = 1'b0, verifyDone = 1'b0;
  logic safetyChangeAccept, verifyPending, heatDemand = 1'b0, burnerOn;
  mod_source_e modSource = MOD_OTHER;
  logic [15:0] loopTemp = 16'h0, setpoint = 16'h0, hysteresis = 16'h0, faultCode = 16'h0;
  logic captureLockout = 1'b0, productIsSteam = 1'b0, dualAsLockout = 1'b0, annLocValid;
  lockout_snap_s snap = '0;
  lockout_rec_s historyRec;
  annunciator_rec_s annRec = '0;
  interlock_rec_s ilkRec = '0;
  logic [23:0] ilkShortName;
  fault_class_e faultClass;
  int numErrors = 0, numChecks = 0, cycleCount = 0;
  reg_rsp_s got;

  boiler_control_register_map boiler_control_register_map_inst (.clock, .reset_n(resetN),
    .req, .rsp, .accessLevel, .makerPasscode, .labelText, .noteText, .makerIdText, .rawTemp,
    .tempEnabled, .tempReg, .speedWord, .modOutIsPercent, .speedInvalid, .rateWord,
    .rateTenths, .rateValid, .safetyChangeReq, .loginOk, .verifyDone, .safetyChangeAccept,
    .verifyPending, .modSource, .heatDemand, .loopTemp, .setpoint, .hysteresis, .burnerOn,
    .captureLockout, .productIsSteam, .snap, .historyRec, .annRec, .ilkRec, .annLocValid,
    .ilkShortName, .faultCode, .dualAsLockout, .faultClass);
  fieldbus_master_model fieldbus_master_model_inst (.clock, .req, .rsp);

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  // Compares one value and counts it; a mismatch is reported at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic wrapUp();
    if (numErrors == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the hundred or so cycles the scenarios need.
  always @(posedge clock) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 3000) begin
      numErrors++;
      wrapUp();
    end
  end

  // Lets one rising edge register the inputs set at this falling edge.
  task automatic tick();
    @(negedge clock);
  endtask

  // Last word of each text window, written and read back over the bus.
  task automatic textWindows();
    logic [15:0] base[3] = '{`ADDR_LABEL, `ADDR_NOTE, `ADDR_MAKER_ID};
    reg_rsp_s rd;
    for (int i = 0; i < 3; i++) begin
      fieldbus_master_model_inst.writeRead(base[i] + 16'h0009, 16'h4a00 + i[15:0], got, rd);
      check("text write exc", {got.valid, got.exc}, 32'h2);
      check("text read", {rd.valid, rd.exc, rd.data}, 32'h24a00 + i);
    end
    check("label alias", labelText[159:144], 32'h4a00);
    check("note alias", noteText[159:144], 32'h4a01);
    check("maker id alias", makerIdText[159:144], 32'h4a02);
  endtask

  // Passcode needs maker level; reserved gaps and foreign addresses behave as set.
  task automatic passcodeAndReserved();
    accessLevel = 2'h1;
    fieldbus_master_model_inst.xfer(1'b1, `ADDR_PASSCODE, 16'h1234, got);
    check("low level refused", {got.exc, got.excCode}, 32'h103);
    check("passcode kept", makerPasscode[15:0], 32'h0);
    accessLevel = `LEVEL_MAKER;
    fieldbus_master_model_inst.xfer(1'b1, `ADDR_PASSCODE, 16'h1234, got);
    check("maker write exc", got.exc, 32'h0);
    check("passcode mirror", makerPasscode[15:0], 32'h1234);
    fieldbus_master_model_inst.xfer(1'b0, `ADDR_PASSCODE, 16'h0000, got);
    check("write-only read", {got.exc, got.excCode}, 32'h102);
    fieldbus_master_model_inst.xfer(1'b1, 16'h052a, 16'hffff, got);
    check("reserved write", got.exc, 32'h0);
    fieldbus_master_model_inst.xfer(1'b0, 16'h052a, 16'h0000, got);
    check("reserved read", {got.exc, got.data}, 32'h0);
    fieldbus_master_model_inst.xfer(1'b0, 16'h0400, 16'h0000, got);
    check("foreign address", {got.exc, got.excCode}, 32'h102);
  endtask

  // Temperature pass-through in range, clamping and the unconfigured marker.
  task automatic temperatures();
    tempEnabled = 1'b1;
    rawTemp = 16'h0140;
    tick();
    check("temp in range", tempReg, 32'h0140);
    rawTemp = 16'hfe0c;
    tick();
    check("temp low clamp", tempReg, 32'hfe70);
    rawTemp = 16'h0600;
    tick();
    check("temp high clamp", tempReg, 32'h0514);
    tempEnabled = 1'b0;
    tick();
    check("temp disabled", tempReg, 32'h8fff);
  endtask

  // Unit flag against the output selection, all four pairings.
  task automatic speedUnits();
    for (int i = 0; i < 4; i++) begin
      speedWord = {i[1], 15'h0100};
      modOutIsPercent = i[0];
      tick();
      check("speed invalid", speedInvalid, i[1] ^ i[0]);
    end
  endtask

  // Commanded rate in both formats, with the step ceiling and one past it.
  task automatic rates();
    logic [15:0] w[7] = '{16'h00c8, 16'h0000, 16'h0064, 16'h00c9, 16'h01ff, 16'h0180, 16'h0100};
    int exp;
    for (int i = 0; i < 7; i++) begin
      rateWord = w[i];
      tick();
      exp = w[i][8] ? (w[i][7:0] * 1000) >> 8 : (w[i][7:0] <= 200 ? w[i][7:0] * 5 : 0);
      check("rate tenths", rateTenths, exp);
      check("rate valid", rateValid, w[i][8] || w[i][7:0] <= 8'hc8);
    end
  endtask

  // Safety change refused without login, then pending until verified.
  task automatic safetyChange();
    safetyChangeReq = 1'b1;
    tick();
    check("no login accept", {safetyChangeAccept, verifyPending}, 32'h0);
    loginOk = 1'b1;
    tick();
    safetyChangeReq = 1'b0;
    check("login accept", {safetyChangeAccept, verifyPending}, 32'h3);
    tick();
    check("still pending", {safetyChangeAccept, verifyPending}, 32'h1);
    verifyDone = 1'b1;
    tick();
    verifyDone = 1'b0;
    check("verified", verifyPending, 32'h0);
    safetyChangeReq = 1'b1;
    verifyDone = 1'b1;
    tick();
    safetyChangeReq = 1'b0;
    verifyDone = 1'b0;
    check("set beats clear", {safetyChangeAccept, verifyPending}, 32'h3);
  endtask

  // Demand switching follows demand; sensor switching uses the hysteresis band.
  task automatic burner();
    logic [15:0] t[4] = '{16'h021c, 16'h0244, 16'h0258, 16'h0230};
    modSource = MOD_DEMAND_SWITCH;
    heatDemand = 1'b1;
    tick();
    check("demand on", burnerOn, 32'h1);
    heatDemand = 1'b0;
    tick();
    check("demand off", burnerOn, 32'h0);
    modSource = MOD_SENSOR_SWITCH;
    setpoint = 16'h0258;
    hysteresis = 16'h0032;
    for (int i = 0; i < 4; i++) begin
      loopTemp = t[i];
      heatDemand = i[0];
      tick();
      check("sensor switch", burnerOn, i < 2);
    end
    loopTemp = t[0];
    tick();
    check("sensor on again", burnerOn, 32'h1);
    modSource = MOD_OTHER;
    tick();
    check("other mode off", burnerOn, 32'h0);
  endtask

  // Record byte order, the product-dependent slot and holding between captures.
  task automatic lockoutHistory();
    snap.code = 16'h000a;
    snap.cycles = 32'h11223344;
    snap.hours = 32'h55667788;
    snap.inletTemp = 16'h0111;
    snap.steamPressure = 16'h0222;
    snap.faultData = 16'habcd;
    captureLockout = 1'b1;
    tick();
    captureLockout = 1'b0;
    check("record code", historyRec[271 -: 16], 32'h000a);
    check("record cycles", historyRec[207 -: 32], 32'h11223344);
    check("record hours", historyRec[175 -: 32], 32'h55667788);
    check("record fault", historyRec[15:0], 32'habcd);
    check("record inlet", historyRec[95 -: 16], 32'h0111);
    productIsSteam = 1'b1;
    snap.code = 16'h0003;
    tick();
    check("record held", historyRec[271 -: 16], 32'h000a);
    captureLockout = 1'b1;
    tick();
    captureLockout = 1'b0;
    check("record steam", historyRec[95 -: 16], 32'h0222);
  endtask

  // Location codes up to one past the last, and the interlock short name.
  task automatic namingRecords();
    ilkRec.shortName = 24'h414243;
    for (int i = 0; i < 6; i++) begin
      annRec.location = i[15:0];
      tick();
      check("location valid", annLocValid, i <= 4);
    end
    check("interlock short", ilkShortName, 32'h414243);
  endtask

  // Every listed code in both settings of the dual-class choice.
  task automatic faultClasses();
    logic [1:0] e;
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 17; c++) begin
        dualAsLockout = d[0];
        faultCode = c[15:0];
        tick();
        e = (c == 0) ? CLASS_NONE : (c > 15) ? CLASS_UNLISTED :
          (c inside {1, 2, 10, 11, 15}) ? CLASS_LOCKOUT :
          (c inside {13, 14} && d == 1) ? CLASS_LOCKOUT : CLASS_HOLD;
        check("fault class", faultClass, e);
      end
    end
  endtask

  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    repeat (6) @(negedge clock);
    resetN = 1'b1;
    tick();
    textWindows();
    passcodeAndReserved();
    temperatures();
    speedUnits();
    rates();
    safetyChange();
    burner();
    lockoutHistory();
    namingRecords();
    faultClasses();
    wrapUp();
  end
endmodule
`default_nettype wire

// [testbench/fieldbus_master_model.sv]
// Behavioural fieldbus master that issues single register requests.
`timescale 1ns/10ps
`default_nettype none
module fieldbus_master_model (
  input wire logic clock,
  output var boiler_pkg::reg_req_s req,
  input wire boiler_pkg::reg_rsp_s rsp
);
  import boiler_pkg::*;
  initial begin
    req = '0;
  end
  // One-cycle strobe, then the answer is taken in the following cycle.
  // Released lines show the inverse, so a stale address can never pass as live.
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] data,
      output reg_rsp_s got);
    @(negedge clock);
    req <= '{valid: 1'b1, write: wr, addr: addr, data: data};
    @(negedge clock);
    req <= '{valid: 1'b0, write: ~wr, addr: ~addr, data: ~data};
    got = rsp;
  endtask
  // Write, then read the same word in the very next cycle, as the bus allows.
  task automatic writeRead(input logic [15:0] addr, input logic [15:0] data,
      output reg_rsp_s gotWr, output reg_rsp_s gotRd);
    @(negedge clock);
    req <= '{valid: 1'b1, write: 1'b1, addr: addr, data: data};
    @(negedge clock);
    req <= '{valid: 1'b1, write: 1'b0, addr: addr, data: ~data};
    gotWr = rsp;
    @(negedge clock);
    req <= '{valid: 1'b0, write: 1'b1, addr: ~addr, data: data};
    gotRd = rsp;
  endtask
endmodule
`default_nettype wire
